// File: hw/bdm_decoder.sv
// bdm_decoder: banked data memory, indirect pointers and access bank
// assumes the core clock is the quarter clock and the cpu tracks q_phase
`timescale 1ns/1ps
`default_nettype none
module bdm_decoder
  import bdm_pkg::*;
#(
  parameter int GEN_DEPTH = 1024
)(
  // clock and reset
  input  wire  logic        clk,
  input  wire  logic        sys_rst,
  // request, taken in q1
  input  wire  logic        req_valid,
  input  wire  logic        req_move,
  input  wire  logic        req_banked,
  input  wire  logic        req_write,
  input  wire  logic [7:0]  req_file_addr,
  input  wire  logic [11:0] req_src_addr,
  input  wire  logic [11:0] req_dst_addr,
  // write data, taken in q4; plus-w offset, taken in q1
  input  wire  logic [7:0]  wr_data,
  input  wire  logic [7:0]  working_register,
  // status and read data
  output logic       [1:0]  q_phase,
  output logic              req_ready,
  output logic              busy,
  output logic       [7:0]  rd_data,
  output logic              rd_valid,
  output logic       [3:0]  bank_select,
  output logic       [11:0] eff_addr
);
  import bdm_pkg::*;

  typedef struct packed {
    logic        is_bsr;
    logic        is_lo;
    logic        is_hi;
    logic        is_ind;
    bdm_ind_e    kind;
    logic [1:0]  idx;
  } bdm_dec_s;

  typedef struct packed {
    logic [11:0] eff;
    logic        null_acc;
    logic        step_inc;
    logic        step_dec;
    logic [1:0]  idx;
  } bdm_res_s;

  typedef struct packed {
    bdm_state_e  state;
    logic [1:0]  phase;
    logic [3:0]  bank_sel;
    logic [11:0] eff_addr;
    logic        null_acc;
    logic        do_write;
    logic        step_inc;
    logic        step_dec;
    logic [1:0]  step_idx;
    logic [11:0] dst_addr;
    logic [7:0]  hold;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        req_ready;
    logic        busy;
  } bdm_core_s;

  bdm_core_s        st_ff;
  bdm_core_s        nxt_st;
  logic [3:0][11:0] ptrs;
  logic [2:0][11:0] ptr_val;
  logic [2:0]       ptr_wr_lo;
  logic [2:0]       ptr_wr_hi;
  logic [2:0]       ptr_inc;
  logic [2:0]       ptr_dec;
  logic [7:0]       wval;
  logic             gen_we;
  logic [7:0]       gen_rdata;
  logic [11:0]      direct_addr;
  bdm_dec_s         eff_dec;
  bdm_res_s         res;
  logic [7:0]       sfr_val;
  logic [7:0]       rd_val;
  logic             accept;

  function automatic bdm_dec_s decode(input logic [11:0] a);
    bdm_dec_s d;
    d = '0;
    case (a)
      BANK_SEL_OFS:     d.is_bsr = 1'b1;
      PTR0_LO_OFS:      d.is_lo = 1'b1;
      PTR1_LO_OFS:      begin d.is_lo = 1'b1; d.idx = 2'd1; end
      PTR2_LO_OFS:      begin d.is_lo = 1'b1; d.idx = 2'd2; end
      PTR0_HI_OFS:      d.is_hi = 1'b1;
      PTR1_HI_OFS:      begin d.is_hi = 1'b1; d.idx = 2'd1; end
      PTR2_HI_OFS:      begin d.is_hi = 1'b1; d.idx = 2'd2; end
      IND0_OPERAND_OFS: d.is_ind = 1'b1;
      IND1_OPERAND_OFS: begin d.is_ind = 1'b1; d.idx = 2'd1; end
      IND2_OPERAND_OFS: begin d.is_ind = 1'b1; d.idx = 2'd2; end
      IND0_POSTINC_OFS: begin d.is_ind = 1'b1; d.kind = BDM_IND_POSTINC; end
      IND1_POSTINC_OFS: begin d.is_ind = 1'b1; d.kind = BDM_IND_POSTINC; d.idx = 2'd1; end
      IND2_POSTINC_OFS: begin d.is_ind = 1'b1; d.kind = BDM_IND_POSTINC; d.idx = 2'd2; end
      IND0_POSTDEC_OFS: begin d.is_ind = 1'b1; d.kind = BDM_IND_POSTDEC; end
      IND1_POSTDEC_OFS: begin d.is_ind = 1'b1; d.kind = BDM_IND_POSTDEC; d.idx = 2'd1; end
      IND2_POSTDEC_OFS: begin d.is_ind = 1'b1; d.kind = BDM_IND_POSTDEC; d.idx = 2'd2; end
      IND0_PREINC_OFS:  begin d.is_ind = 1'b1; d.kind = BDM_IND_PREINC; end
      IND1_PREINC_OFS:  begin d.is_ind = 1'b1; d.kind = BDM_IND_PREINC; d.idx = 2'd1; end
      IND2_PREINC_OFS:  begin d.is_ind = 1'b1; d.kind = BDM_IND_PREINC; d.idx = 2'd2; end
      IND0_PLUSW_OFS:   begin d.is_ind = 1'b1; d.kind = BDM_IND_PLUSW; end
      IND1_PLUSW_OFS:   begin d.is_ind = 1'b1; d.kind = BDM_IND_PLUSW; d.idx = 2'd1; end
      IND2_PLUSW_OFS:   begin d.is_ind = 1'b1; d.kind = BDM_IND_PLUSW; d.idx = 2'd2; end
      default:          d = '0;
    endcase
    return d;
  endfunction

  // indirect operands are virtual: they only redirect through a pointer
  function automatic bdm_res_s resolve(input logic [11:0] a, input logic [7:0] w,
                                       input logic [3:0][11:0] p);
    bdm_dec_s    d;
    bdm_dec_s    d2;
    bdm_res_s    r;
    logic [11:0] base;
    d = decode(a);
    base = p[d.idx];
    r = '0;
    r.eff = a;
    r.idx = d.idx;
    if (d.is_ind) begin
      case (d.kind)
        BDM_IND_PLUSW:   r.eff = base + {{4{w[7]}}, w};
        BDM_IND_PREINC:  begin r.eff = base + 12'h001; r.step_inc = 1'b1; end
        BDM_IND_POSTINC: begin r.eff = base; r.step_inc = 1'b1; end
        BDM_IND_POSTDEC: begin r.eff = base; r.step_dec = 1'b1; end
        default:         r.eff = base;
      endcase
      d2 = decode(r.eff);
      r.null_acc = d2.is_ind;
    end
    return r;
  endfunction

  // access bank or banked direct address
  always_comb begin
    if (req_banked) direct_addr = {st_ff.bank_sel, req_file_addr};
    else if (req_file_addr < ACCESS_SPLIT) direct_addr = {ACCESS_LOW_BANK, req_file_addr};
    else direct_addr = {ACCESS_HIGH_BANK, req_file_addr};
  end

  assign accept  = (st_ff.phase == Q1_PHASE) && (st_ff.state == BDM_IDLE) && req_valid;
  assign eff_dec = decode(st_ff.eff_addr);
  assign wval    = (st_ff.state == BDM_MOVE_DST) ? st_ff.hold : wr_data;

  // special area reads; unused addresses give zero
  always_comb begin
    if (eff_dec.is_bsr) sfr_val = {4'h0, st_ff.bank_sel};
    else if (eff_dec.is_lo) sfr_val = ptrs[eff_dec.idx][7:0];
    else if (eff_dec.is_hi) sfr_val = {4'h0, ptrs[eff_dec.idx][11:8]};
    else sfr_val = 8'h00;
  end

  always_comb begin
    if (st_ff.null_acc) rd_val = 8'h00;
    else if (st_ff.eff_addr >= SPECIAL_AREA_BASE) rd_val = sfr_val;
    else rd_val = gen_rdata;
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rd_valid = 1'b0;
    nxt_st.phase = st_ff.phase + 2'd1;
    res = '0;
    gen_we = 1'b0;
    ptr_wr_lo = '0;
    ptr_wr_hi = '0;
    ptr_inc = '0;
    ptr_dec = '0;
    case (st_ff.phase)
      Q1_PHASE: begin
        if (accept || st_ff.state == BDM_MOVE_DST) begin
          if (st_ff.state == BDM_MOVE_DST) res = resolve(st_ff.dst_addr, working_register, ptrs);
          else if (req_move) res = resolve(req_src_addr, working_register, ptrs);
          else res = resolve(direct_addr, working_register, ptrs);
          nxt_st.eff_addr = res.eff;
          nxt_st.null_acc = res.null_acc;
          nxt_st.step_inc = res.step_inc;
          nxt_st.step_dec = res.step_dec;
          nxt_st.step_idx = res.idx;
          if (accept) begin
            nxt_st.state = req_move ? BDM_MOVE_SRC : BDM_FILE;
            nxt_st.do_write = req_write && !req_move;
            nxt_st.dst_addr = req_dst_addr;
          end
        end
      end
      Q2_PHASE: begin
        if (st_ff.state == BDM_FILE || st_ff.state == BDM_MOVE_SRC) begin
          nxt_st.rd_data = rd_val;
          nxt_st.hold = rd_val;
          nxt_st.rd_valid = 1'b1;
        end
      end
      Q3_PHASE: begin
        nxt_st.rd_valid = 1'b0;
      end
      Q4_PHASE: begin
        if ((st_ff.state == BDM_FILE && st_ff.do_write) || st_ff.state == BDM_MOVE_DST) begin
          if (st_ff.null_acc) gen_we = 1'b0;
          else if (eff_dec.is_bsr) nxt_st.bank_sel = wval[3:0];
          else if (eff_dec.is_lo) ptr_wr_lo[eff_dec.idx] = 1'b1;
          else if (eff_dec.is_hi) ptr_wr_hi[eff_dec.idx] = 1'b1;
          else gen_we = st_ff.eff_addr < SPECIAL_AREA_BASE;
        end
        if (st_ff.state != BDM_IDLE) begin
          ptr_inc[st_ff.step_idx] = st_ff.step_inc;
          ptr_dec[st_ff.step_idx] = st_ff.step_dec;
        end
        case (st_ff.state)
          BDM_MOVE_SRC: nxt_st.state = BDM_MOVE_DST;
          default:      nxt_st.state = BDM_IDLE;
        endcase
        nxt_st.do_write = 1'b0;
        nxt_st.step_inc = 1'b0;
        nxt_st.step_dec = 1'b0;
      end
      default: nxt_st.phase = Q1_PHASE;
    endcase
    nxt_st.req_ready = (nxt_st.phase == Q1_PHASE) && (nxt_st.state == BDM_IDLE);
    nxt_st.busy = nxt_st.state != BDM_IDLE;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.state <= BDM_IDLE;
      st_ff.phase <= Q1_PHASE;
      st_ff.bank_sel <= BANK_SEL_RESET;
      st_ff.req_ready <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // three indirect pointers
  assign ptrs = {12'h000, ptr_val};
  for (genvar i = 0; i < PTR_COUNT; i++) begin : g_ptr
    bdm_ptr u_ptr (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .wr_lo    (ptr_wr_lo[i]),
      .wr_hi    (ptr_wr_hi[i]),
      .wdata    (wval),
      .step_inc (ptr_inc[i]),
      .step_dec (ptr_dec[i]),
      .ptr      (ptr_val[i])
    );
  end

  bdm_gen_store #(
    .DEPTH (GEN_DEPTH)
  ) u_store (
    .clk   (clk),
    .we    (gen_we),
    .waddr (st_ff.eff_addr),
    .wdata (wval),
    .raddr (st_ff.eff_addr),
    .rdata (gen_rdata)
  );

  assign q_phase     = st_ff.phase;
  assign req_ready   = st_ff.req_ready;
  assign busy        = st_ff.busy;
  assign rd_data     = st_ff.rd_data;
  assign rd_valid    = st_ff.rd_valid;
  assign bank_select = st_ff.bank_sel;
  assign eff_addr    = st_ff.eff_addr;

  a_phase_steps: assert property (@(posedge clk) disable iff (sys_rst)
    1'b1 |=> q_phase == 2'($past(q_phase) + 2'd1))
    else $error("quarter counter did not advance");

  a_read_in_q2: assert property (@(posedge clk) disable iff (sys_rst)
    rd_valid |-> q_phase == Q3_PHASE && $past(q_phase) == Q2_PHASE)
    else $error("operand read outside the second quarter");

  a_bank_write: assert property (@(posedge clk) disable iff (sys_rst)
    (st_ff.phase == Q4_PHASE && st_ff.state == BDM_FILE && st_ff.do_write
     && eff_dec.is_bsr && !st_ff.null_acc) |=> bank_select == $past(wr_data[3:0]))
    else $error("bank select not loaded from low nibble");

  a_banked_addr: assert property (@(posedge clk) disable iff (sys_rst)
    (accept && !req_move && req_banked && st_ff.bank_sel != ACCESS_HIGH_BANK)
    |=> eff_addr == {$past(bank_select), $past(req_file_addr)})
    else $error("banked direct address wrong");

  a_access_low: assert property (@(posedge clk) disable iff (sys_rst)
    (accept && !req_move && !req_banked && req_file_addr < ACCESS_SPLIT)
    |=> eff_addr == {ACCESS_LOW_BANK, $past(req_file_addr)})
    else $error("access bank low segment address wrong");

  a_unimpl_zero: assert property (@(posedge clk) disable iff (sys_rst)
    (rd_valid && eff_addr >= SPECIAL_AREA_BASE && !eff_dec.is_bsr && !eff_dec.is_lo
     && !eff_dec.is_hi) |-> rd_data == 8'h00)
    else $error("unimplemented location read nonzero");

  a_move_length: assert property (@(posedge clk) disable iff (sys_rst)
    (accept && req_move) |=> busy [*7] ##1 !busy && req_ready)
    else $error("move did not take two instruction cycles");

  a_ind_plain: assert property (@(posedge clk) disable iff (sys_rst)
    (accept && !req_move && !req_banked && req_file_addr == IND0_OPERAND_OFS[7:0])
    |=> eff_addr == $past(ptrs[0]))
    else $error("indirect operand not routed through its pointer");

  a_store_gated: assert property (@(posedge clk) disable iff (sys_rst)
    gen_we |-> st_ff.eff_addr < SPECIAL_AREA_BASE && !st_ff.null_acc && q_phase == Q4_PHASE)
    else $error("store written outside general area or q4");

  a_access_high: assert property (@(posedge clk) disable iff (sys_rst)
    (accept && !req_move && !req_banked && req_file_addr == BANK_SEL_OFS[7:0])
    |=> eff_addr == {ACCESS_HIGH_BANK, $past(req_file_addr)})
    else $error("access bank high segment address wrong");

  a_file_length: assert property (@(posedge clk) disable iff (sys_rst)
    (accept && !req_move) |=> busy [*3] ##1 !busy && req_ready)
    else $error("file access did not take one instruction cycle");
endmodule // bdm_decoder
`default_nettype wire

// File: hw/bdm_pkg.sv
// bdm_pkg: constants and types of the banked data memory decoder
// assumes one core clock, four clocks to an instruction cycle
package bdm_pkg;
  localparam int          ADDR_W            = 12;
  localparam int          DATA_W            = 8;
  localparam int          BANK_COUNT        = 16;
  localparam int          BANK_BYTES        = 256;
  localparam int          SPACE_BYTES       = 4096;
  localparam int          PTR_COUNT         = 3;
  localparam logic [11:0] SPECIAL_AREA_BASE = 12'h0F80;
  localparam logic [11:0] SPECIAL_AREA_TOP  = 12'h0FFF;
  localparam logic [7:0]  ACCESS_SPLIT      = 8'h80;
  localparam logic [3:0]  ACCESS_LOW_BANK   = 4'h0;
  localparam logic [3:0]  ACCESS_HIGH_BANK  = 4'hF;
  localparam logic [3:0]  BANK_SEL_RESET    = 4'h0;
  localparam logic [11:0] PTR_RESET         = 12'h0000;
  // instruction cycle quarters
  localparam logic [1:0]  Q1_PHASE          = 2'h0;
  localparam logic [1:0]  Q2_PHASE          = 2'h1;
  localparam logic [1:0]  Q3_PHASE          = 2'h2;
  localparam logic [1:0]  Q4_PHASE          = 2'h3;
  // register offsets
  localparam logic [11:0] PTR2_LO_OFS       = 12'h0FD9;
  localparam logic [11:0] PTR2_HI_OFS       = 12'h0FDA;
  localparam logic [11:0] IND2_PLUSW_OFS    = 12'h0FDB;
  localparam logic [11:0] IND2_PREINC_OFS   = 12'h0FDC;
  localparam logic [11:0] IND2_POSTDEC_OFS  = 12'h0FDD;
  localparam logic [11:0] IND2_POSTINC_OFS  = 12'h0FDE;
  localparam logic [11:0] IND2_OPERAND_OFS  = 12'h0FDF;
  localparam logic [11:0] BANK_SEL_OFS      = 12'h0FE0;
  localparam logic [11:0] PTR1_LO_OFS       = 12'h0FE1;
  localparam logic [11:0] PTR1_HI_OFS       = 12'h0FE2;
  localparam logic [11:0] IND1_PLUSW_OFS    = 12'h0FE3;
  localparam logic [11:0] IND1_PREINC_OFS   = 12'h0FE4;
  localparam logic [11:0] IND1_POSTDEC_OFS  = 12'h0FE5;
  localparam logic [11:0] IND1_POSTINC_OFS  = 12'h0FE6;
  localparam logic [11:0] IND1_OPERAND_OFS  = 12'h0FE7;
  localparam logic [11:0] PTR0_LO_OFS       = 12'h0FE9;
  localparam logic [11:0] PTR0_HI_OFS       = 12'h0FEA;
  localparam logic [11:0] IND0_PLUSW_OFS    = 12'h0FEB;
  localparam logic [11:0] IND0_PREINC_OFS   = 12'h0FEC;
  localparam logic [11:0] IND0_POSTDEC_OFS  = 12'h0FED;
  localparam logic [11:0] IND0_POSTINC_OFS  = 12'h0FEE;
  localparam logic [11:0] IND0_OPERAND_OFS  = 12'h0FEF;

  typedef enum logic [1:0] {
    BDM_IDLE     = 2'b00,
    BDM_FILE     = 2'b01,
    BDM_MOVE_SRC = 2'b10,
    BDM_MOVE_DST = 2'b11
  } bdm_state_e;

  typedef enum logic [2:0] {
    BDM_IND_PLAIN   = 3'b000,
    BDM_IND_POSTINC = 3'b001,
    BDM_IND_POSTDEC = 3'b010,
    BDM_IND_PREINC  = 3'b011,
    BDM_IND_PLUSW   = 3'b100
  } bdm_ind_e;
endpackage

// File: hw/bdm_ptr.sv
// bdm_ptr: one 12-bit indirect pointer with byte loads and steps
// assumes the caller never steps and loads in the same clock on purpose
`timescale 1ns/1ps
`default_nettype none
module bdm_ptr
  import bdm_pkg::*;
(
  // clock and reset
  input  wire  logic        clk,
  input  wire  logic        sys_rst,
  // control
  input  wire  logic        wr_lo,
  input  wire  logic        wr_hi,
  input  wire  logic [7:0]  wdata,
  input  wire  logic        step_inc,
  input  wire  logic        step_dec,
  // value
  output logic       [11:0] ptr
);
  typedef struct packed {
    logic [11:0] ptr;
  } bdm_ptr_s;

  bdm_ptr_s st_ff;
  bdm_ptr_s nxt_st;

  // a byte load wins over a step
  always_comb begin
    nxt_st = st_ff;
    if (wr_lo || wr_hi) begin
      if (wr_lo) nxt_st.ptr[7:0] = wdata;
      if (wr_hi) nxt_st.ptr[11:8] = wdata[3:0];
    end else if (step_inc) begin
      nxt_st.ptr = st_ff.ptr + 12'h001;
    end else if (step_dec) begin
      nxt_st.ptr = st_ff.ptr - 12'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) st_ff.ptr <= PTR_RESET;
    else st_ff <= nxt_st;
  end

  assign ptr = st_ff.ptr;
endmodule // bdm_ptr
`default_nettype wire

// File: hw/bdm_gen_store.sv
// bdm_gen_store: general storage bytes held in flip-flops
// assumes writes are already gated to the general area; drops those at or above DEPTH
`timescale 1ns/1ps
`default_nettype none
module bdm_gen_store
  import bdm_pkg::*;
#(
  parameter int DEPTH = 1024
)(
  // clock
  input  wire  logic        clk,
  // write port
  input  wire  logic        we,
  input  wire  logic [11:0] waddr,
  input  wire  logic [7:0]  wdata,
  // read port
  input  wire  logic [11:0] raddr,
  output logic       [7:0]  rdata
);
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
  } bdm_store_s;

  bdm_store_s st_ff;
  bdm_store_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (we && int'(waddr) < DEPTH) nxt_st.mem[waddr] = wdata;
  end

  // no reset: contents survive every reset
  always_ff @(posedge clk) begin
    st_ff <= nxt_st;
  end

  assign rdata = (int'(raddr) < DEPTH) ? st_ff.mem[raddr] : 8'h00;
endmodule // bdm_gen_store
`default_nettype wire

// File: verif/bdm_cpu_model.sv
// bdm_cpu_model: instruction execution side issuing data memory requests
// assumes the handshake and quarter phase outputs of bdm_decoder
`timescale 1ns/1ps
`default_nettype none
module bdm_cpu_model (
  // clock
  input  wire  logic        clk,
  // decoder status
  input  wire  logic [1:0]  q_phase,
  input  wire  logic        req_ready,
  input  wire  logic        busy,
  input  wire  logic [7:0]  rd_data,
  input  wire  logic        rd_valid,
  input  wire  logic [11:0] eff_addr,
  // requests
  output logic              req_valid,
  output logic              req_move,
  output logic              req_banked,
  output logic              req_write,
  output logic       [7:0]  req_file_addr,
  output logic       [11:0] req_src_addr,
  output logic       [11:0] req_dst_addr,
  output logic       [7:0]  wr_data,
  output logic       [7:0]  working_register
);
  initial begin
    req_valid        = 1'b0;
    req_move         = 1'b0;
    req_banked       = 1'b0;
    req_write        = 1'b0;
    req_file_addr    = 8'h00;
    req_src_addr     = 12'h000;
    req_dst_addr     = 12'h000;
    wr_data          = 8'h00;
    working_register = 8'h00;
  end

  // plus-w offset, changed between requests at a falling edge
  task automatic set_w(input logic [7:0] w);
    working_register = w;
  endtask

  // one request per instruction cycle, held from a falling edge over the q1 edge
  task automatic req(input logic mv, input logic bk, input logic wr, input logic [7:0] fa,
                     input logic [11:0] src, input logic [11:0] dst, input logic [7:0] wd,
                     output logic [7:0] rd, output logic [11:0] ea, output logic [1:0] qv,
                     output int nb);
    int n;
    n = 0;
    @(negedge clk);
    while (!(q_phase === 2'h0 && req_ready === 1'b1) && n < 40) begin
      @(negedge clk);
      n++;
    end
    req_valid     = 1'b1;
    req_move      = mv;
    req_banked    = bk;
    req_write     = wr;
    req_file_addr = fa;
    req_src_addr  = src;
    req_dst_addr  = dst;
    wr_data       = wd;
    @(negedge clk);
    req_valid = 1'b0;
    ea = eff_addr;
    rd = 8'h00;
    qv = 2'h3;
    nb = 0;
    // operand read seen in its quarter, write data held over the q4 edge
    while (busy === 1'b1 && nb < 20) begin
      if (rd_valid === 1'b1) begin
        rd = rd_data;
        qv = q_phase;
      end
      @(negedge clk);
      nb++;
    end
    // released fields no longer show the last value
    req_file_addr = ~req_file_addr;
    req_src_addr  = ~req_src_addr;
    req_dst_addr  = ~req_dst_addr;
    wr_data       = ~wr_data;
  endtask
endmodule // bdm_cpu_model
`default_nettype wire

// File: verif/test_banked_data_memory_decoder.sv
// test_banked_data_memory_decoder: directed scenarios for bdm_decoder
// assumes bdm_cpu_model as the requesting side, one 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
module test_banked_data_memory_decoder;
  import bdm_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  wire logic [1:0] q_phase;
  wire logic req_ready, busy, rd_valid, req_valid, req_move, req_banked, req_write;
  wire logic [7:0] rd_data, req_file_addr, wr_data, working_register;
  wire logic [3:0] bank_select;
  wire logic [11:0] eff_addr, req_src_addr, req_dst_addr;
  int n_errors = 0;
  int n_compared = 0;
  logic [7:0] r_rd;
  logic [11:0] r_ea;
  logic [1:0] r_qv;
  int r_nb;

  always #12.5 clk = ~clk;

  bdm_decoder #(.GEN_DEPTH(1024)) dut (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
    .req_move(req_move), .req_banked(req_banked), .req_write(req_write),
    .req_file_addr(req_file_addr), .req_src_addr(req_src_addr), .req_dst_addr(req_dst_addr),
    .wr_data(wr_data), .working_register(working_register), .q_phase(q_phase),
    .req_ready(req_ready), .busy(busy), .rd_data(rd_data), .rd_valid(rd_valid),
    .bank_select(bank_select), .eff_addr(eff_addr));

  bdm_cpu_model cpu (.clk(clk), .q_phase(q_phase), .req_ready(req_ready), .busy(busy),
    .rd_data(rd_data), .rd_valid(rd_valid), .eff_addr(eff_addr), .req_valid(req_valid),
    .req_move(req_move), .req_banked(req_banked), .req_write(req_write),
    .req_file_addr(req_file_addr), .req_src_addr(req_src_addr), .req_dst_addr(req_dst_addr),
    .wr_data(wr_data), .working_register(working_register));

  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic fa(input logic bk, input logic w, input logic [7:0] a, input logic [7:0] d);
    cpu.req(1'b0, bk, w, a, 12'h000, 12'h000, d, r_rd, r_ea, r_qv, r_nb);
  endtask

  task automatic set_bank(input logic [7:0] b);
    fa(1'b0, 1'b1, 8'hE0, b);
  endtask

  task automatic pulse_reset();
    @(negedge clk);
    sys_rst = 1'b1;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic t_reset();
    chk("q_phase", 12'h000, {10'h000, q_phase});
    chk("req_ready", 12'h001, {11'h000, req_ready});
    chk("busy", 12'h000, {11'h000, busy});
    chk("bank_select", 12'h000, {8'h00, bank_select});
    chk("eff_addr", 12'h000, eff_addr);
    fa(1'b0, 1'b0, 8'hE9, 8'h00);
    chk("ptr0 low reset", 12'h000, {4'h0, r_rd});
    $display("test reset done");
  endtask

  task automatic t_bank();
    set_bank(8'hFF);
    fa(1'b0, 1'b0, 8'hE0, 8'h00);
    chk("bank read", 12'h00F, {4'h0, r_rd});
    chk("bank port", 12'h00F, {8'h00, bank_select});
    chk("bank eff", 12'hFE0, r_ea);
    $display("test bank done");
  endtask

  task automatic t_direct();
    set_bank(8'h01);
    fa(1'b1, 1'b1, 8'h20, 8'hA5);
    chk("banked eff", 12'h120, r_ea);
    chk("file busy clocks", 12'h003, 12'(r_nb));
    set_bank(8'h00);
    fa(1'b1, 1'b1, 8'h20, 8'h3C);
    chk("bank0 eff", 12'h020, r_ea);
    set_bank(8'h01);
    fa(1'b1, 1'b0, 8'h20, 8'h00);
    chk("bank1 data", 12'h0A5, {4'h0, r_rd});
    chk("read quarter", 12'h002, {10'h000, r_qv});
    fa(1'b0, 1'b0, 8'h20, 8'h00);
    chk("access low data", 12'h03C, {4'h0, r_rd});
    chk("access low eff", 12'h020, r_ea);
    $display("test direct done");
  endtask

  task automatic t_unimpl();
    set_bank(8'h05);
    fa(1'b1, 1'b1, 8'h00, 8'h77);
    chk("far eff", 12'h500, r_ea);
    fa(1'b1, 1'b0, 8'h00, 8'h00);
    chk("far read", 12'h000, {4'h0, r_rd});
    fa(1'b0, 1'b1, 8'h80, 8'h55);
    fa(1'b0, 1'b0, 8'h80, 8'h00);
    chk("special read", 12'h000, {4'h0, r_rd});
    set_bank(8'h01);
    fa(1'b1, 1'b0, 8'h20, 8'h00);
    chk("storage kept", 12'h0A5, {4'h0, r_rd});
    $display("test unimplemented done");
  endtask

  task automatic t_indirect();
    fa(1'b0, 1'b1, 8'hEA, 8'hF1);
    fa(1'b0, 1'b1, 8'hE9, 8'h23);
    fa(1'b0, 1'b0, 8'hEA, 8'h00);
    chk("ptr high", 12'h001, {4'h0, r_rd});
    fa(1'b0, 1'b1, 8'hEF, 8'h5A);
    chk("indirect eff", 12'h123, r_ea);
    fa(1'b1, 1'b0, 8'h23, 8'h00);
    chk("indirect target", 12'h05A, {4'h0, r_rd});
    fa(1'b0, 1'b0, 8'hEE, 8'h00);
    chk("postinc data", 12'h05A, {4'h0, r_rd});
    fa(1'b0, 1'b0, 8'hE9, 8'h00);
    chk("postinc step", 12'h024, {4'h0, r_rd});
    fa(1'b0, 1'b1, 8'hEA, 8'h0F);
    fa(1'b0, 1'b1, 8'hE9, 8'hEF);
    fa(1'b0, 1'b0, 8'hEF, 8'h00);
    chk("virtual operand", 12'h000, {4'h0, r_rd});
    $display("test indirect done");
  endtask

  task automatic t_modes();
    fa(1'b0, 1'b1, 8'hE1, 8'h40);
    fa(1'b0, 1'b1, 8'hE4, 8'h11);
    chk("preinc eff", 12'h041, r_ea);
    fa(1'b0, 1'b0, 8'hE5, 8'h00);
    chk("postdec data", 12'h011, {4'h0, r_rd});
    chk("postdec eff", 12'h041, r_ea);
    fa(1'b0, 1'b0, 8'hE1, 8'h00);
    chk("postdec step", 12'h040, {4'h0, r_rd});
    fa(1'b0, 1'b1, 8'hD9, 8'h42);
    cpu.set_w(8'hFF);
    fa(1'b0, 1'b0, 8'hDB, 8'h00);
    chk("plus w eff", 12'h041, r_ea);
    chk("plus w data", 12'h011, {4'h0, r_rd});
    cpu.set_w(8'h00);
    $display("test pointer modes done");
  endtask

  task automatic t_move();
    cpu.req(1'b1, 1'b0, 1'b0, 8'h00, 12'h120, 12'h3FF, 8'h00, r_rd, r_ea, r_qv, r_nb);
    chk("move source", 12'h0A5, {4'h0, r_rd});
    chk("move eff", 12'h120, r_ea);
    chk("move busy clocks", 12'h007, 12'(r_nb));
    set_bank(8'h03);
    fa(1'b1, 1'b0, 8'hFF, 8'h00);
    chk("move dest", 12'h0A5, {4'h0, r_rd});
    $display("test move done");
  endtask

  task automatic t_keep();
    pulse_reset();
    fa(1'b0, 1'b0, 8'hE0, 8'h00);
    chk("bank after reset", 12'h000, {4'h0, r_rd});
    set_bank(8'h03);
    fa(1'b1, 1'b0, 8'hFF, 8'h00);
    chk("storage over reset", 12'h0A5, {4'h0, r_rd});
    $display("test reset keep done");
  endtask

  initial begin
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_bank();
    t_direct();
    t_unimpl();
    t_indirect();
    t_modes();
    t_move();
    t_keep();
    conclude();
  end

  initial begin
    #100000;
    n_errors++;
    conclude();
  end
endmodule // test_banked_data_memory_decoder
`default_nettype wire
